// ==== inc/dfr_regs.vh ====
// constants of the disturbance and fault recorder control block
`ifndef DFR_REGS_VH
`define DFR_REGS_VH
// ------------------------------------------------------------------
// timing and limits
// ------------------------------------------------------------------
`define DFR_CLK_PERIOD_NS      5
`define DFR_TICK_NS            1000000
`define DFR_TICK_CYCLES        (`DFR_TICK_NS / `DFR_CLK_PERIOD_NS)
`define DFR_POWER_CYCLE_NS     20000000
`define DFR_SAMPLES_PER_CYCLE  32
`define DFR_SAMPLE_CYCLES      (`DFR_POWER_CYCLE_NS / (`DFR_SAMPLES_PER_CYCLE * `DFR_CLK_PERIOD_NS))
`define DFR_FLUSH_CYCLES       64
`define DFR_MAX_LEN_MS         14'd15000
`define DFR_STORE_MS           18'd120000
`define DFR_PCT_MAX            7'd100
`define DFR_FAULT_DEPTH        20
// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define DFR_OFS_CTRL           8'h00
`define DFR_OFS_LIMIT          8'h04
`define DFR_OFS_PCT            8'h08
`define DFR_OFS_MDELAY         8'h0c
`define DFR_OFS_DR_STAT        8'h10
`define DFR_OFS_DR_DEL         8'h14
`define DFR_OFS_DR_SEL         8'h18
`define DFR_OFS_DR_TIMES       8'h1c
`define DFR_OFS_DR_TAG         8'h20
`define DFR_OFS_FR_STAT        8'h24
`define DFR_OFS_FR_IDX         8'h28
`define DFR_OFS_FR_TAG         8'h2c
`define DFR_OFS_FR_TIMES       8'h30
`define DFR_OFS_FR_INFO        8'h34
`define DFR_OFS_FR_MEAS        8'h38
`define DFR_OFS_FAULT_NO       8'h3c
// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define DFR_CTRL_WRAP_BIT      0
`define DFR_CTRL_POLICY_BIT    1
`define DFR_CTRL_MANUAL_BIT    2
`define DFR_CTRL_SEL_LSB       8
`define DFR_PCT_TAIL_LSB       8
`define DFR_DEL_CUR_BIT        0
`define DFR_DEL_ALL_BIT        1
`define DFR_DEL_KEY_LSB        16
`define DFR_DEL_KEY            16'ha5c3
`define DFR_STAT_COUNT_LSB     8
`define DFR_STAT_FULL_BIT      16
`define DFR_STAT_READY_BIT     17
`define DFR_INFO_TRIP_LSB      4
`define DFR_INFO_TRIPPED_BIT   8
`define DFR_INFO_TTTV_BIT      9
// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define DFR_RST_LIMIT          14'd2000
`define DFR_RST_LEAD_PCT       7'd20
`define DFR_RST_TAIL_PCT       7'd20
`define DFR_RST_SEL            8'hff
`define DFR_RST_MDELAY         16'h0000
`endif

// ==== logic/dfr_rec_mem.v ====
// fault record store with registered read data
`timescale 1ns/100ps
module dfr_rec_mem #(
   parameter WIDTH = 104,
   parameter DEPTH = 20,
   parameter AW    = 5
) (
   // clock
   input  wire             clk_i,
   // write port
   input  wire             wr_en_i,
   input  wire [AW-1:0]    wr_addr_i,
   input  wire [WIDTH-1:0] wr_data_i,
   // read port
   input  wire [AW-1:0]    rd_addr_i,
   output wire [WIDTH-1:0] rd_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [WIDTH-1:0] rd_data_ff;

   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_ff <= mem[rd_addr_i];
   end

   assign rd_data_o = rd_data_ff;
endmodule // dfr_rec_mem

// ==== logic/dfr_recorder_ctrl.v ====
// disturbance capture controller and fault logger with apb registers
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "dfr_regs.vh"
module dfr_recorder_ctrl #(
   parameter NMOD          = 8,
   parameter MOD_W         = 3,
   parameter MEAS_W        = 32,
   parameter TICK_CYCLES   = `DFR_TICK_CYCLES,
   parameter SAMPLE_CYCLES = `DFR_SAMPLE_CYCLES,
   parameter FLUSH_CYCLES  = `DFR_FLUSH_CYCLES
) (
   // clock and reset
   input  wire              REF_CLK_I,
   input  wire              RST_I,
   // apb slave
   input  wire              PSEL_I,
   input  wire              PENABLE_I,
   input  wire              PWRITE_I,
   input  wire [7:0]        PADDR_I,
   input  wire [31:0]       PWDATA_I,
   output wire [31:0]       PRDATA_O,
   output wire              PREADY_O,
   output wire              PSLVERR_O,
   // protection modules
   input  wire [7:0]        TRIG_I,
   input  wire [NMOD-1:0]   PICKUP_I,
   input  wire [NMOD-1:0]   TRIP_I,
   input  wire [MEAS_W-1:0] MEAS_I,
   // recorder outputs
   output wire              DR_SAMPLE_O,
   output wire              DR_ACTIVE_O,
   output wire              DR_FLUSH_O,
   output wire              FAULT_NOTIFY_O,
   output wire              NV_SAVE_O,
   output wire [MEAS_W+71:0] NV_REC_O
);
   localparam REC_W = MEAS_W + 72;
   localparam DS_IDLE = 2'd0, DS_EVENT = 2'd1, DS_TAIL = 2'd2, DS_FLUSH = 2'd3;
   localparam [4:0] DEPTH = `DFR_FAULT_DEPTH;
   localparam [31:0] TICK_LAST  = TICK_CYCLES - 1;
   localparam [31:0] SMP_LAST   = SAMPLE_CYCLES - 1;
   localparam [31:0] FLUSH_LAST = FLUSH_CYCLES - 1;

   // ------------------------------------------------------------------
   // time base
   // ------------------------------------------------------------------
   reg [17:0] tick_cnt_ff;
   reg [17:0] smp_cnt_ff;
   reg        smp_ff;
   wire       tick = (tick_cnt_ff == TICK_LAST[17:0]);
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tick_cnt_ff <= 18'h0;
         smp_cnt_ff  <= 18'h0;
         smp_ff      <= 1'b0;
      end else begin
         tick_cnt_ff <= tick ? 18'h0 : tick_cnt_ff + 18'h1;
         smp_ff      <= (smp_cnt_ff == SMP_LAST[17:0]);
         smp_cnt_ff  <= (smp_cnt_ff == SMP_LAST[17:0]) ? 18'h0 : smp_cnt_ff + 18'h1;
      end
   end

   // ------------------------------------------------------------------
   // apb access and configuration
   // ------------------------------------------------------------------
   reg        wrap_ff, policy_ff;
   reg [7:0]  sel_ff;
   reg [13:0] limit_ff;
   reg [6:0]  lead_pct_ff, tail_pct_ff;
   reg [15:0] mdelay_ff;
   reg [7:0]  dsel_ff;
   reg [4:0]  fidx_ff;
   reg        rd_wait_ff;
   reg [31:0] prdata_ff;
   wire       acc    = PSEL_I & PENABLE_I;
   wire       wr     = acc & PWRITE_I;
   wire       manual = wr && PADDR_I == `DFR_OFS_CTRL && PWDATA_I[`DFR_CTRL_MANUAL_BIT];
   wire       key_ok = wr && PADDR_I == `DFR_OFS_DR_DEL &&
                       PWDATA_I[`DFR_DEL_KEY_LSB +: 16] == `DFR_DEL_KEY;
   wire       del_cur = key_ok & PWDATA_I[`DFR_DEL_CUR_BIT];
   wire       del_all = key_ok & PWDATA_I[`DFR_DEL_ALL_BIT];
   wire [13:0] wlim = (PWDATA_I > {18'h0, `DFR_MAX_LEN_MS}) ? `DFR_MAX_LEN_MS : PWDATA_I[13:0];
   wire [6:0]  wlp  = (PWDATA_I[6:0] > `DFR_PCT_MAX) ? `DFR_PCT_MAX : PWDATA_I[6:0];
   wire [6:0]  wtp  = (PWDATA_I[`DFR_PCT_TAIL_LSB +: 7] > `DFR_PCT_MAX) ? `DFR_PCT_MAX :
                      PWDATA_I[`DFR_PCT_TAIL_LSB +: 7];
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wrap_ff     <= 1'b0;
         policy_ff   <= 1'b0;
         sel_ff      <= `DFR_RST_SEL;
         limit_ff    <= `DFR_RST_LIMIT;
         lead_pct_ff <= `DFR_RST_LEAD_PCT;
         tail_pct_ff <= `DFR_RST_TAIL_PCT;
         mdelay_ff   <= `DFR_RST_MDELAY;
         dsel_ff     <= 8'h0;
         fidx_ff     <= 5'h0;
      end else if (wr) begin
         if (PADDR_I == `DFR_OFS_CTRL) begin
            wrap_ff   <= PWDATA_I[`DFR_CTRL_WRAP_BIT];
            policy_ff <= PWDATA_I[`DFR_CTRL_POLICY_BIT];
            sel_ff    <= PWDATA_I[`DFR_CTRL_SEL_LSB +: 8];
         end else if (PADDR_I == `DFR_OFS_LIMIT) begin
            limit_ff <= wlim;
         end else if (PADDR_I == `DFR_OFS_PCT) begin
            lead_pct_ff <= wlp;
            tail_pct_ff <= wtp;
         end else if (PADDR_I == `DFR_OFS_MDELAY) begin
            mdelay_ff <= PWDATA_I[15:0];
         end else if (PADDR_I == `DFR_OFS_DR_SEL) begin
            dsel_ff <= PWDATA_I[7:0];
         end else if (PADDR_I == `DFR_OFS_FR_IDX) begin
            fidx_ff <= (PWDATA_I[4:0] >= DEPTH) ? DEPTH - 5'd1 : PWDATA_I[4:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // disturbance capture controller
   // ------------------------------------------------------------------
   reg [1:0]  ds_ff;
   reg [7:0]  trig_q_ff, ev_src_ff;
   reg [13:0] elapsed_ff, ev_ms_ff, tail_ms_ff;
   reg [17:0] used_ff;
   reg [7:0]  dcount_ff;
   reg [15:0] flush_ff;
   reg [15:0] fault_no_ff, grid_no_ff, dtag_f_ff, dtag_g_ff;
   wire [20:0] lead_prod = limit_ff * lead_pct_ff;
   wire [20:0] tail_prod = limit_ff * tail_pct_ff;
   wire [20:0] lead_q = lead_prod / 21'd100;
   wire [20:0] tail_q = tail_prod / 21'd100;
   wire [13:0] lead_ms = lead_q[13:0];
   wire [13:0] tail_set = tail_q[13:0];
   wire [7:0]  trig_edge = TRIG_I & ~trig_q_ff & sel_ff;
   wire        full = (used_ff + {4'h0, limit_ff}) > `DFR_STORE_MS;
   wire        dr_ready = (ds_ff == DS_IDLE) & (~full | wrap_ff);
   wire        start = dr_ready & ((|trig_edge) | manual);
   wire        at_limit = elapsed_ff >= limit_ff;
   wire        tail_done = (tail_ms_ff >= tail_set) | at_limit;
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ds_ff      <= DS_IDLE;
         trig_q_ff  <= 8'h0;
         ev_src_ff  <= 8'h0;
         elapsed_ff <= 14'h0;
         ev_ms_ff   <= 14'h0;
         tail_ms_ff <= 14'h0;
         used_ff    <= 18'h0;
         dcount_ff  <= 8'h0;
         flush_ff   <= 16'h0;
         dtag_f_ff  <= 16'h0;
         dtag_g_ff  <= 16'h0;
      end else begin
         trig_q_ff <= TRIG_I;
         case (ds_ff)
            DS_IDLE: begin
               if (start) begin
                  ev_src_ff  <= trig_edge;
                  elapsed_ff <= lead_ms;
                  ev_ms_ff   <= 14'h0;
                  tail_ms_ff <= 14'h0;
                  dtag_f_ff  <= fault_no_ff;
                  dtag_g_ff  <= grid_no_ff;
                  if (!full) begin
                     used_ff   <= used_ff + {4'h0, limit_ff};
                     dcount_ff <= dcount_ff + 8'h1;
                  end
                  ds_ff <= DS_EVENT;
               end else if (del_all) begin
                  used_ff   <= 18'h0;
                  dcount_ff <= 8'h0;
               end else if (del_cur && dcount_ff != 8'h0 && dsel_ff < dcount_ff) begin
                  used_ff   <= (used_ff > {4'h0, limit_ff}) ? used_ff - {4'h0, limit_ff} : 18'h0;
                  dcount_ff <= dcount_ff - 8'h1;
               end
            end
            DS_EVENT: begin
               if (at_limit) begin
                  ds_ff    <= DS_FLUSH;
                  flush_ff <= 16'h0;
               end else if (~|(TRIG_I & ev_src_ff)) begin
                  ds_ff <= DS_TAIL;
               end else if (tick) begin
                  elapsed_ff <= elapsed_ff + 14'h1;
                  ev_ms_ff   <= ev_ms_ff + 14'h1;
               end
            end
            DS_TAIL: begin
               if (tail_done) begin
                  ds_ff    <= DS_FLUSH;
                  flush_ff <= 16'h0;
               end else if (tick) begin
                  elapsed_ff <= elapsed_ff + 14'h1;
                  tail_ms_ff <= tail_ms_ff + 14'h1;
               end
            end
            default: begin
               flush_ff <= flush_ff + 16'h1;
               if (flush_ff == FLUSH_LAST[15:0]) begin
                  ds_ff <= DS_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // fault logger
   // ------------------------------------------------------------------
   reg             gp_q_ff, open_ff, tripped_ff, ttt_v_ff, pend_ff;
   reg [MOD_W-1:0] pick_mod_ff, trip_mod_ff;
   reg [15:0]      fl_ms_ff, ttt_ff, md_cnt_ff;
   reg [MEAS_W-1:0] meas_ff;
   reg [4:0]       wptr_ff, fcount_ff;
   reg             notify_ff, nvsave_ff;
   reg [REC_W-1:0] latest_ff;
   wire            gp = |PICKUP_I;
   wire            gt = |TRIP_I;
   wire            gp_rise = gp & ~gp_q_ff;
   wire            gp_fall = ~gp & gp_q_ff;
   wire            first_trip = open_ff & gt & ~tripped_ff;

   function [MOD_W-1:0] first_set;
      input [NMOD-1:0] v;
      integer k;
      begin
         first_set = {MOD_W{1'b0}};
         for (k = NMOD - 1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               first_set = k[MOD_W-1:0];
            end
         end
      end
   endfunction

   wire [MOD_W-1:0]  trip_mod_now = first_set(TRIP_I);
   wire [MEAS_W-1:0] meas_fin = pend_ff ? MEAS_I : meas_ff;
   wire              rec_wr = open_ff & gp_fall & (tripped_ff | policy_ff);
   wire [REC_W-1:0]  rec_data = {meas_fin, ttt_v_ff, tripped_ff, trip_mod_ff, pick_mod_ff,
                                 ttt_ff, fl_ms_ff, grid_no_ff, fault_no_ff};
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         gp_q_ff     <= 1'b0;
         open_ff     <= 1'b0;
         tripped_ff  <= 1'b0;
         ttt_v_ff    <= 1'b0;
         pend_ff     <= 1'b0;
         pick_mod_ff <= {MOD_W{1'b0}};
         trip_mod_ff <= {MOD_W{1'b0}};
         fl_ms_ff    <= 16'h0;
         ttt_ff      <= 16'h0;
         md_cnt_ff   <= 16'h0;
         meas_ff     <= {MEAS_W{1'b0}};
         fault_no_ff <= 16'h0;
         grid_no_ff  <= 16'h0;
         wptr_ff     <= 5'h0;
         fcount_ff   <= 5'h0;
         notify_ff   <= 1'b0;
         nvsave_ff   <= 1'b0;
         latest_ff   <= {REC_W{1'b0}};
      end else begin
         gp_q_ff   <= gp;
         notify_ff <= gp_fall;
         nvsave_ff <= rec_wr;
         if (gp_rise) begin
            open_ff     <= 1'b1;
            tripped_ff  <= 1'b0;
            ttt_v_ff    <= 1'b0;
            pend_ff     <= 1'b0;
            fl_ms_ff    <= 16'h0;
            ttt_ff      <= 16'h0;
            pick_mod_ff <= first_set(PICKUP_I);
            fault_no_ff <= fault_no_ff + 16'h1;
            grid_no_ff  <= grid_no_ff + 16'h1;
         end else if (open_ff) begin
            if (tick && fl_ms_ff != 16'hffff) begin
               fl_ms_ff <= fl_ms_ff + 16'h1;
            end
            if (first_trip) begin
               tripped_ff  <= 1'b1;
               trip_mod_ff <= trip_mod_now;
               ttt_ff      <= fl_ms_ff;
               ttt_v_ff    <= (trip_mod_now == pick_mod_ff);
               md_cnt_ff   <= 16'h0;
               if (mdelay_ff == 16'h0) begin
                  meas_ff <= MEAS_I;
               end else begin
                  pend_ff <= 1'b1;
               end
            end else if (pend_ff) begin
               if (md_cnt_ff >= mdelay_ff || gp_fall) begin
                  meas_ff <= MEAS_I;
                  pend_ff <= 1'b0;
               end else if (tick) begin
                  md_cnt_ff <= md_cnt_ff + 16'h1;
               end
            end
            if (gp_fall) begin
               open_ff <= 1'b0;
            end
         end
         if (rec_wr) begin
            wptr_ff   <= (wptr_ff == DEPTH - 5'd1) ? 5'h0 : wptr_ff + 5'h1;
            fcount_ff <= (fcount_ff == DEPTH) ? DEPTH : fcount_ff + 5'h1;
            latest_ff <= rec_data;
         end
      end
   end

   // ------------------------------------------------------------------
   // fault record store, index 0 is the newest
   // ------------------------------------------------------------------
   wire [5:0]       rd_sum = {1'b0, wptr_ff} + {1'b0, DEPTH} - 6'd1 - {1'b0, fidx_ff};
   wire [4:0]       rd_addr = (rd_sum >= {1'b0, DEPTH}) ? rd_sum[4:0] - DEPTH : rd_sum[4:0];
   wire [REC_W-1:0] rd_rec;
   dfr_rec_mem #(
      .WIDTH (REC_W),
      .DEPTH (`DFR_FAULT_DEPTH),
      .AW    (5)
   ) u_mem (
      .clk_i     (REF_CLK_I),
      .wr_en_i   (rec_wr),
      .wr_addr_i (wptr_ff),
      .wr_data_i (rec_data),
      .rd_addr_i (rd_addr),
      .rd_data_o (rd_rec)
   );

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   reg [31:0] rmux;
   reg        unmapped;
   always @* begin
      rmux     = 32'h0;
      unmapped = 1'b0;
      if (PADDR_I == `DFR_OFS_CTRL) begin
         rmux = {16'h0, sel_ff, 6'h0, policy_ff, wrap_ff};
      end else if (PADDR_I == `DFR_OFS_LIMIT) begin
         rmux = {18'h0, limit_ff};
      end else if (PADDR_I == `DFR_OFS_PCT) begin
         rmux = {17'h0, tail_pct_ff, 1'b0, lead_pct_ff};
      end else if (PADDR_I == `DFR_OFS_MDELAY) begin
         rmux = {16'h0, mdelay_ff};
      end else if (PADDR_I == `DFR_OFS_DR_STAT) begin
         rmux = {14'h0, dr_ready, full, dcount_ff, 6'h0, ds_ff};
      end else if (PADDR_I == `DFR_OFS_DR_DEL) begin
         rmux = 32'h0;
      end else if (PADDR_I == `DFR_OFS_DR_SEL) begin
         rmux = {24'h0, dsel_ff};
      end else if (PADDR_I == `DFR_OFS_DR_TIMES) begin
         rmux = {2'h0, tail_ms_ff, 2'h0, ev_ms_ff};
      end else if (PADDR_I == `DFR_OFS_DR_TAG) begin
         rmux = {dtag_g_ff, dtag_f_ff};
      end else if (PADDR_I == `DFR_OFS_FR_STAT) begin
         rmux = {19'h0, wptr_ff, 3'h0, fcount_ff};
      end else if (PADDR_I == `DFR_OFS_FR_IDX) begin
         rmux = {27'h0, fidx_ff};
      end else if (PADDR_I == `DFR_OFS_FR_TAG) begin
         rmux = rd_rec[31:0];
      end else if (PADDR_I == `DFR_OFS_FR_TIMES) begin
         rmux = rd_rec[63:32];
      end else if (PADDR_I == `DFR_OFS_FR_INFO) begin
         rmux = {22'h0, rd_rec[71], rd_rec[70], 1'b0, rd_rec[69:67], 1'b0, rd_rec[66:64]};
      end else if (PADDR_I == `DFR_OFS_FR_MEAS) begin
         rmux = rd_rec[REC_W-1:72];
      end else if (PADDR_I == `DFR_OFS_FAULT_NO) begin
         rmux = {grid_no_ff, fault_no_ff};
      end else begin
         unmapped = 1'b1;
      end
   end

   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rd_wait_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else begin
         rd_wait_ff <= acc & ~PWRITE_I & ~rd_wait_ff;
         if (acc & ~PWRITE_I & ~rd_wait_ff) begin
            prdata_ff <= rmux;
         end
      end
   end

   assign PREADY_O       = acc & (PWRITE_I | rd_wait_ff);
   assign PSLVERR_O      = PREADY_O & unmapped;
   assign PRDATA_O       = prdata_ff;
   assign DR_SAMPLE_O    = smp_ff;
   assign DR_ACTIVE_O    = (ds_ff == DS_EVENT) | (ds_ff == DS_TAIL);
   assign DR_FLUSH_O     = (ds_ff == DS_FLUSH);
   assign FAULT_NOTIFY_O = notify_ff;
   assign NV_SAVE_O      = nvsave_ff;
   assign NV_REC_O       = latest_ff;
endmodule // dfr_recorder_ctrl

// ==== verif/dfr_chk.sv ====
// assertion checker for the recorder control block ports
`timescale 1ns/100ps
module dfr_chk #(parameter NMOD = 8) (
   input wire            REF_CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I,
   input wire [7:0]      PADDR_I, TRIG_I,
   input wire            PREADY_O, PSLVERR_O,
   input wire [NMOD-1:0] PICKUP_I,
   input wire            DR_SAMPLE_O, DR_ACTIVE_O, DR_FLUSH_O, FAULT_NOTIFY_O, NV_SAVE_O
);
   reg [7:0] trg_ff;
   reg       gp_ff;
   reg       fell_ff;
   wire      trg_rise = |(TRIG_I & ~trg_ff);
   always @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         trg_ff  <= 8'h00;
         gp_ff   <= 1'b0;
         fell_ff <= 1'b0;
      end else begin
         trg_ff  <= TRIG_I;
         gp_ff   <= |PICKUP_I;
         fell_ff <= gp_ff & ~(|PICKUP_I);
      end
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   AST_NOTIFY: assert property (FAULT_NOTIFY_O == fell_ff)
      else $error("notify not tied to pickup fall");
   AST_SAVE: assert property (NV_SAVE_O |-> FAULT_NOTIFY_O)
      else $error("record saved without pickup fall");
   AST_SAMPLE: assert property (DR_SAMPLE_O |=> (!DR_SAMPLE_O)[*7] ##1 DR_SAMPLE_O)
      else $error("sample strobe spacing wrong");
   AST_WR_RDY: assert property (PSEL_I && PENABLE_I && PWRITE_I |-> PREADY_O)
      else $error("write not ready at once");
   AST_RD_RDY: assert property (PSEL_I && !PENABLE_I && !PWRITE_I |=> !PREADY_O ##1 PREADY_O)
      else $error("read wait state wrong");
   AST_ERR: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I > 8'h3c || |PADDR_I[1:0]))
      else $error("slave error decode wrong");
   AST_START: assert property ($rose(DR_ACTIVE_O) |->
      $past(trg_rise) || $past(PSEL_I) || $past(PSEL_I, 2))
      else $error("capture started without edge or request");
   AST_FLUSH: assert property ($fell(DR_ACTIVE_O) |-> DR_FLUSH_O)
      else $error("record end without write-out");
   AST_FLEN: assert property ($rose(DR_FLUSH_O) |-> DR_FLUSH_O[*4] ##1 !DR_FLUSH_O)
      else $error("write-out length wrong");
   AST_EXCL: assert property (!(DR_ACTIVE_O && DR_FLUSH_O))
      else $error("recording during write-out");
   COV_REC: cover property ($fell(DR_FLUSH_O));
   COV_FLT: cover property (NV_SAVE_O);
   COV_ERR: cover property (PSLVERR_O);
endmodule // dfr_chk

// ==== verif/dfr_prot_mdl.sv ====
// protection module model driving triggers, pickups, trips and measurements
`timescale 1ns/100ps
module dfr_prot_mdl (
   input  wire       clk_i,
   input  wire [7:0] trg_i, pu_i, tr_i,
   output reg  [7:0] trig_o, pickup_o, trip_o,
   output reg [31:0] meas_o
);
   initial begin
      {trig_o, pickup_o, trip_o} = 24'h000000;
      meas_o = 32'h00000000;
   end
   // levels follow commands one cycle late, measurement moves every cycle
   always @(posedge clk_i) begin
      trig_o   <= trg_i;
      pickup_o <= pu_i;
      trip_o   <= tr_i;
      meas_o   <= meas_o + 32'h01010101;
   end
endmodule // dfr_prot_mdl

// ==== verif/disturbance_fault_recorder_ctrl_tb.sv ====
// self-checking testbench of the recorder control block
`timescale 1ns/100ps
`include "dfr_regs.vh"
module disturbance_fault_recorder_ctrl_tb;
   logic       clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, er, prdy, perr, smp, act, fls;
   logic [7:0] paddr = 0, trg = 0, pu = 0, tr = 0, trig, pick, trip;
   logic [31:0] pwdata = 0, prdata, rd, meas, tm;
   logic [103:0] nvrec;
   int bad_count = 0, n_tests = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   dfr_prot_mdl i_mdl (.clk_i(clk), .trg_i(trg), .pu_i(pu), .tr_i(tr), .trig_o(trig),
      .pickup_o(pick), .trip_o(trip), .meas_o(meas));
   dfr_recorder_ctrl #(.TICK_CYCLES(10), .SAMPLE_CYCLES(8), .FLUSH_CYCLES(4)) i_dut (
      .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(prdy),
      .PSLVERR_O(perr), .TRIG_I(trig), .PICKUP_I(pick), .TRIP_I(trip), .MEAS_I(meas),
      .DR_SAMPLE_O(smp), .DR_ACTIVE_O(act), .DR_FLUSH_O(fls), .FAULT_NOTIFY_O(),
      .NV_SAVE_O(), .NV_REC_O(nvrec));
   task test_done;
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prdata;
      er = perr;
      {psel, pen} <= 2'b00;
   endtask
   task rdc(input logic [7:0] a, input string n, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task rec_end;
      @(negedge fls);
      repeat (20) @(posedge clk);
   endtask
   task flt(input logic [7:0] p, input logic [7:0] t);
      // start clear of the ms tick so that the timer values are exact
      while (cyc % 10 != 0) @(posedge clk);
      pu <= p;
      repeat (50) @(posedge clk);
      tr <= t;
      // trip reaches the block two edges on, with the value the model shows then
      tm = (cyc + 2) * 32'h01010101;
      repeat (70) @(posedge clk);
      {pu, tr} <= 16'h0000;
      repeat (10) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdc(`DFR_OFS_PCT, "pct", 32'h00001414);
      rdc(`DFR_OFS_CTRL, "ctrl", 32'h0000ff00);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      apb(1'b1, `DFR_OFS_LIMIT, 32'd20000);
      rdc(`DFR_OFS_LIMIT, "limit", 32'd15000);
      apb(1'b1, `DFR_OFS_LIMIT, 32'd100);
      trg <= 8'h02;
      rec_end;
      rdc(`DFR_OFS_DR_TIMES, "times", 32'h00000050);
      rdc(`DFR_OFS_DR_STAT, "stat", 32'h00020100);
      trg <= 8'h06;
      rec_end;
      rdc(`DFR_OFS_DR_TIMES, "times", 32'h00000050);
      trg <= 8'h00;
      repeat (20) @(posedge clk);
      apb(1'b1, `DFR_OFS_CTRL, 32'h0000ff04);
      rec_end;
      rdc(`DFR_OFS_DR_TIMES, "times", 32'h00140000);
      apb(1'b1, `DFR_OFS_CTRL, 32'h0000fe00);
      trg <= 8'h01;
      repeat (20) @(posedge clk);
      rdc(`DFR_OFS_DR_STAT, "stat", 32'h00020300);
      apb(1'b1, `DFR_OFS_DR_DEL, 32'h00000002);
      rdc(`DFR_OFS_DR_STAT, "stat", 32'h00020300);
      apb(1'b1, `DFR_OFS_DR_DEL, 32'ha5c30002);
      rdc(`DFR_OFS_DR_STAT, "stat", 32'h00020000);
      flt(8'h04, 8'h04);
      rdc(`DFR_OFS_FR_INFO, "info", 32'h00000322);
      rdc(`DFR_OFS_FR_TIMES, "frtimes", 32'h0005000c);
      rdc(`DFR_OFS_FR_MEAS, "meas", tm);
      flt(8'h02, 8'h08);
      rdc(`DFR_OFS_FR_INFO, "info", 32'h00000131);
      flt(8'h01, 8'h00);
      apb(1'b0, `DFR_OFS_FR_STAT, 32'h0);
      chk("frcount", 32'h2, rd & 32'h1f);
      apb(1'b1, `DFR_OFS_CTRL, 32'h0000ff02);
      flt(8'h01, 8'h00);
      apb(1'b0, `DFR_OFS_FR_STAT, 32'h0);
      chk("frcount", 32'h3, rd & 32'h1f);
      rdc(`DFR_OFS_FAULT_NO, "faultno", 32'h00040004);
      chk("nvrec", 32'h00040004, nvrec[31:0]);
      test_done;
   end
endmodule // disturbance_fault_recorder_ctrl_tb
bind dfr_recorder_ctrl dfr_chk #(.NMOD(NMOD)) i_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .TRIG_I(TRIG_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PICKUP_I(PICKUP_I),
   .DR_SAMPLE_O(DR_SAMPLE_O), .DR_ACTIVE_O(DR_ACTIVE_O), .DR_FLUSH_O(DR_FLUSH_O),
   .FAULT_NOTIFY_O(FAULT_NOTIFY_O), .NV_SAVE_O(NV_SAVE_O));
